// File: inc/rcc_regs.vh
`ifndef RCC_REGS_VH
`define RCC_REGS_VH

// Register byte addresses on the bus.
`define RCC_ADR_W             12
`define RCC_RUN_CFG_ADDR      12'h060
`define RCC_SEC_CFG_ADDR      12'h070
`define RCC_STATUS_ADDR       12'h074

// Run-mode clock configuration register layout.
`define RCC_RUN_CFG_RESET     32'h07803AD1
`define RCC_RUN_CFG_WMASK     32'h0FC02FF3
`define RCC_RUN_CFG_ONES      32'h00001000
`define RCC_ACG_BIT           27
`define RCC_SYSTEM_DIVISOR_MSB        26
`define RCC_SYSTEM_DIVISOR_LSB        23
`define RCC_USEDIV_BIT        22
`define RCC_PLL_POWER_DOWN_BIT         13
`define RCC_BYPASS_BIT        11
`define RCC_CRYSTAL_VALUE_MSB          10
`define RCC_CRYSTAL_VALUE_LSB          6
`define RCC_OSC_MSB           5
`define RCC_OSC_LSB           4
`define RCC_PIOSCDIS_BIT      1
`define RCC_MOSCDIS_BIT       0

// Secondary clock configuration register layout.
`define RCC_SEC_CFG_RESET     32'h07800000
`define RCC_SEC_CFG_WMASK     32'h87800000
`define RCC_SEC_OVR_BIT       31
`define RCC_SEC_DIV_MSB       26
`define RCC_SEC_DIV_LSB       23

// Status register layout.
`define RCC_ST_PLL_USED_BIT   0
`define RCC_ST_DIV_USED_BIT   1
`define RCC_ST_DIV_MSB        7
`define RCC_ST_DIV_LSB        4
`define RCC_ST_OSC_MSB        9
`define RCC_ST_OSC_LSB        8
`define RCC_ST_PLL_SRC_BIT    10

// Oscillator select codes.
`define RCC_OSC_MAIN          2'h0
`define RCC_OSC_PRECISION_INTERNAL_OSC         2'h1
`define RCC_OSC_PRECISION_INTERNAL_OSC_DIV4    2'h2
`define RCC_OSC_LF            2'h3

// Source sampling channels and the internal oscillator prescale.
`define RCC_NSRC              4
`define RCC_SRC_MAIN          0
`define RCC_SRC_PRECISION_INTERNAL_OSC         1
`define RCC_SRC_LF            2
`define RCC_SRC_PLL           3
`define RCC_PRECISION_INTERNAL_OSC_DIV4_LAST   2'h3

// Power mode codes for the gating selector.
`define RCC_MODE_RUN          2'h0
`define RCC_MODE_SLEEP        2'h1
`define RCC_MODE_DEEP         2'h2

`endif

// File: rtl/rcc_clk_div.v
`timescale 1ns/100ps
`include "rcc_regs.vh"

module rcc_clk_div (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       src_tick_i,
  input  wire       div_en_i,
  input  wire [3:0] div_val_i,
  output wire       boundary_o,
  output reg        clk_en_o,
  output wire       div_used_o,
  output wire [3:0] div_cur_o
);

  reg [3:0] cnt_q;
  reg [3:0] div_q;
  reg       en_q;

  // New settings are taken only while the count stands at zero, so a
  // period that has started always runs to its full length.
  assign boundary_o = (cnt_q == 4'h0);
  assign div_used_o = en_q;
  assign div_cur_o  = div_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q    <= 4'h0;
      div_q    <= 4'hF;
      en_q     <= 1'b0;
      clk_en_o <= 1'b0;
    end else begin
      clk_en_o <= 1'b0;
      if (cnt_q == 4'h0) begin
        div_q <= div_val_i;
        en_q  <= div_en_i;
      end
      if (src_tick_i) begin
        if (!((cnt_q == 4'h0) ? div_en_i : en_q)) begin
          clk_en_o <= 1'b1;
          cnt_q    <= 4'h0;
        end else if (cnt_q == ((cnt_q == 4'h0) ? div_val_i : div_q)) begin
          clk_en_o <= 1'b1;
          cnt_q    <= 4'h0;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end

endmodule // rcc_clk_div

// File: rtl/rcc_gate_sel.v
`timescale 1ns/100ps
`include "rcc_regs.vh"

module rcc_gate_sel (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        auto_gating_enable_i,
  input  wire [1:0]  mode_i,
  input  wire [31:0] run_gating_set_i,
  input  wire [31:0] sleep_gating_set_i,
  input  wire [31:0] deep_sleep_gating_set_i,
  output reg  [31:0] periph_clk_en_o
);

  reg [31:0] sel_d;

  always @* begin
    case (mode_i)
      `RCC_MODE_SLEEP: sel_d = auto_gating_enable_i ? sleep_gating_set_i
                                                    : run_gating_set_i;
      `RCC_MODE_DEEP:  sel_d = auto_gating_enable_i ? deep_sleep_gating_set_i
                                                    : run_gating_set_i;
      default:         sel_d = run_gating_set_i;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      periph_clk_en_o <= 32'h00000000;
    end else begin
      periph_clk_en_o <= sel_d;
    end
  end

endmodule // rcc_gate_sel

// File: rtl/rcc_top.v
`timescale 1ns/100ps
`include "rcc_regs.vh"

module rcc_top (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [11:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [3:0]  minimum_divisor_cap_i,
  input  wire        sleep_i,
  input  wire        deep_sleep_i,
  input  wire [31:0] run_gating_set_i,
  input  wire [31:0] sleep_gating_set_i,
  input  wire [31:0] deep_sleep_gating_set_i,
  input  wire        main_osc_i,
  input  wire        precision_internal_osc_i,
  input  wire        lf_osc_i,
  input  wire        pll_clk_i,
  output wire        sys_clk_en_o,
  output wire [31:0] periph_clk_en_o,
  output wire        pll_power_down_o,
  output wire        pll_bypass_o,
  output wire [4:0]  crystal_value_o,
  output wire        main_osc_disable_o,
  output wire        precision_internal_osc_disable_o
);

  // Register state.
  reg  [31:0] run_cfg_q;
  reg  [31:0] run_cfg_d;
  reg  [31:0] sec_cfg_q;
  reg  [31:0] sec_cfg_d;
  reg  [31:0] rd_d;
  wire        wb_req;
  wire        wb_wr;
  wire [31:0] byte_mask;

  // Source sampling.
  wire [`RCC_NSRC-1:0] src_raw;
  wire [`RCC_NSRC-1:0] src_tick;
  reg  [1:0]           precision_internal_osc_pre_q;
  reg                  precision_internal_osc_div4_tick;

  // Clock path selection.
  reg  [1:0]  osc_sel_q;
  reg         pll_sel_q;
  reg         osc_tick;
  wire        sel_tick;
  wire        pll_used;
  wire        div_used_req;
  wire [3:0]  div_prog;
  wire [3:0]  div_eff;
  wire        div_boundary;
  wire        div_used_cur;
  wire [3:0]  div_cur;
  reg  [1:0]  power_mode;
  wire [31:0] status;

  // Configuration fields.
  wire        auto_gating_enable;
  wire [3:0]  system_divisor;
  wire        divider_enable;
  wire        secondary_config_override;
  wire [3:0]  secondary_divisor;
  wire [1:0]  oscillator_select;

  assign auto_gating_enable        = run_cfg_q[`RCC_ACG_BIT];
  assign system_divisor            = run_cfg_q[`RCC_SYSTEM_DIVISOR_MSB:`RCC_SYSTEM_DIVISOR_LSB];
  assign divider_enable            = run_cfg_q[`RCC_USEDIV_BIT];
  assign secondary_config_override = sec_cfg_q[`RCC_SEC_OVR_BIT];
  assign secondary_divisor         = sec_cfg_q[`RCC_SEC_DIV_MSB:`RCC_SEC_DIV_LSB];
  assign oscillator_select         = run_cfg_q[`RCC_OSC_MSB:`RCC_OSC_LSB];

  assign pll_power_down_o   = run_cfg_q[`RCC_PLL_POWER_DOWN_BIT];
  assign pll_bypass_o       = run_cfg_q[`RCC_BYPASS_BIT];
  assign crystal_value_o    = run_cfg_q[`RCC_CRYSTAL_VALUE_MSB:`RCC_CRYSTAL_VALUE_LSB];
  assign main_osc_disable_o = run_cfg_q[`RCC_MOSCDIS_BIT];
  assign precision_internal_osc_disable_o    = run_cfg_q[`RCC_PIOSCDIS_BIT];

  // Bus slave. Every access, mapped or not, is answered one cycle after
  // the strobe; unmapped reads return zero and unmapped writes are lost.
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_req & wb_we_i;
  assign byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always @* begin
    run_cfg_d = ((run_cfg_q & ~byte_mask) | (wb_dat_i & byte_mask))
                & `RCC_RUN_CFG_WMASK;
    run_cfg_d = run_cfg_d | `RCC_RUN_CFG_ONES;
    sec_cfg_d = ((sec_cfg_q & ~byte_mask) | (wb_dat_i & byte_mask))
                & `RCC_SEC_CFG_WMASK;
  end

  always @* begin
    case (wb_adr_i)
      `RCC_RUN_CFG_ADDR: rd_d = run_cfg_q;
      `RCC_SEC_CFG_ADDR: rd_d = sec_cfg_q;
      `RCC_STATUS_ADDR:  rd_d = status;
      default:           rd_d = 32'h00000000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      run_cfg_q <= `RCC_RUN_CFG_RESET;
      sec_cfg_q <= `RCC_SEC_CFG_RESET;
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        wb_dat_o <= wb_we_i ? 32'h00000000 : rd_d;
      end
      if (wb_wr && (wb_adr_i == `RCC_RUN_CFG_ADDR)) begin
        run_cfg_q <= run_cfg_d;
      end
      if (wb_wr && (wb_adr_i == `RCC_SEC_CFG_ADDR)) begin
        sec_cfg_q <= sec_cfg_d;
      end
    end
  end

  // The oscillators and the PLL run on clocks of their own. They are
  // sampled here, so each source must toggle at less than half of clk_i.
  assign src_raw = {pll_clk_i, lf_osc_i, precision_internal_osc_i, main_osc_i};

  genvar gi;
  generate
    for (gi = 0; gi < `RCC_NSRC; gi = gi + 1) begin : g_src
      reg meta_q;
      reg sync_q;
      reg prev_q;
      always @(posedge clk_i) begin
        if (rst_i) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
          prev_q <= 1'b0;
        end else begin
          meta_q <= src_raw[gi];
          sync_q <= meta_q;
          prev_q <= sync_q;
        end
      end
      assign src_tick[gi] = sync_q & ~prev_q;
    end
  endgenerate

  // Divide-by-four of the internal oscillator, counted on its rising edges.
  always @(posedge clk_i) begin
    if (rst_i) begin
      precision_internal_osc_pre_q <= 2'h0;
    end else if (src_tick[`RCC_SRC_PRECISION_INTERNAL_OSC]) begin
      precision_internal_osc_pre_q <= precision_internal_osc_pre_q + 2'h1;
    end
  end

  always @* begin
    precision_internal_osc_div4_tick = src_tick[`RCC_SRC_PRECISION_INTERNAL_OSC] &
                      (precision_internal_osc_pre_q == `RCC_PRECISION_INTERNAL_OSC_DIV4_LAST);
  end

  always @* begin
    case (osc_sel_q)
      `RCC_OSC_MAIN:       osc_tick = src_tick[`RCC_SRC_MAIN];
      `RCC_OSC_PRECISION_INTERNAL_OSC:      osc_tick = src_tick[`RCC_SRC_PRECISION_INTERNAL_OSC];
      `RCC_OSC_PRECISION_INTERNAL_OSC_DIV4: osc_tick = precision_internal_osc_div4_tick;
      default:             osc_tick = src_tick[`RCC_SRC_LF];
    endcase
  end

  // The PLL is in use when bypass is clear; a powered-down PLL gives no
  // edges, which is why bypass has to be set before power-down.
  assign pll_used = ~run_cfg_q[`RCC_BYPASS_BIT];

  // The source choice is applied only at a divider boundary. If the old
  // source stops while the count is above zero, no boundary comes and it hangs.
  always @(posedge clk_i) begin
    if (rst_i) begin
      osc_sel_q <= `RCC_OSC_PRECISION_INTERNAL_OSC;
      pll_sel_q <= 1'b0;
    end else if (div_boundary) begin
      osc_sel_q <= oscillator_select;
      pll_sel_q <= pll_used;
    end
  end

  assign sel_tick = pll_sel_q ? src_tick[`RCC_SRC_PLL] : osc_tick;

  assign div_prog = secondary_config_override ? secondary_divisor
                                              : system_divisor;
  assign div_eff  = (pll_used && (div_prog < minimum_divisor_cap_i))
                    ? minimum_divisor_cap_i
                    : div_prog;
  assign div_used_req = divider_enable | pll_used;

  rcc_clk_div u_div (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .src_tick_i (sel_tick),
    .div_en_i   (div_used_req),
    .div_val_i  (div_eff),
    .boundary_o (div_boundary),
    .clk_en_o   (sys_clk_en_o),
    .div_used_o (div_used_cur),
    .div_cur_o  (div_cur)
  );

  // Deep sleep takes precedence if both requests are raised.
  always @* begin
    if (deep_sleep_i) begin
      power_mode = `RCC_MODE_DEEP;
    end else if (sleep_i) begin
      power_mode = `RCC_MODE_SLEEP;
    end else begin
      power_mode = `RCC_MODE_RUN;
    end
  end

  rcc_gate_sel u_gate (
    .clk_i                   (clk_i),
    .rst_i                   (rst_i),
    .auto_gating_enable_i    (auto_gating_enable),
    .mode_i                  (power_mode),
    .run_gating_set_i        (run_gating_set_i),
    .sleep_gating_set_i      (sleep_gating_set_i),
    .deep_sleep_gating_set_i (deep_sleep_gating_set_i),
    .periph_clk_en_o         (periph_clk_en_o)
  );

  // Status shows the settings actually applied, which lag the register
  // by up to one output period; only bit 0 follows the bypass bit at once.
  assign status = {21'h000000,
                   pll_sel_q,
                   osc_sel_q,
                   div_cur,
                   2'h0,
                   div_used_cur,
                   pll_used};

endmodule // rcc_top

// File: test/rcc_checker.sv
`timescale 1ns/100ps
module rcc_checker (
  input logic        clk_i,
  input logic        rst_i,
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_we_i,
  input logic [11:0] wb_adr_i,
  input logic [3:0]  wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic        wb_ack_o,
  input logic        sleep_i,
  input logic        deep_sleep_i,
  input logic [31:0] run_gating_set_i,
  input logic [31:0] deep_sleep_gating_set_i,
  input logic [31:0] periph_clk_en_o,
  input logic        sys_clk_en_o,
  input logic        pll_power_down_o,
  input logic        pll_bypass_o,
  input logic [4:0]  crystal_value_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Shadow of the auto gating bit, so gating checks know which set applies.
  logic acg_q;
  wire  req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire  wr_run = req && wb_we_i && wb_adr_i == 12'h060;
  always @(posedge clk_i) begin
    if (rst_i) acg_q <= 1'b0;
    else if (wr_run && wb_sel_i[3]) acg_q <= wb_dat_i[27];
  end
  property p_ack_lat; req |=> wb_ack_o; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_run_set; !sleep_i && !deep_sleep_i |=> periph_clk_en_o == $past(run_gating_set_i);
  endproperty
  a_run_set: assert property (p_run_set) else $error("run set not used");
  property p_auto; acg_q && deep_sleep_i |=> periph_clk_en_o == $past(deep_sleep_gating_set_i);
  endproperty
  a_auto: assert property (p_auto) else $error("deep set not used");
  property p_no_auto; !acg_q && sleep_i |=> periph_clk_en_o == $past(run_gating_set_i);
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("run set dropped");
  property p_rst_val; $fell(rst_i) |-> pll_power_down_o && pll_bypass_o && crystal_value_o == 5'h0B;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("bad reset value");
  property p_wr_pll; wr_run && wb_sel_i[1] |=>
    {pll_power_down_o, pll_bypass_o} == $past({wb_dat_i[13], wb_dat_i[11]}); endproperty
  a_wr_pll: assert property (p_wr_pll) else $error("pll bits not written");
  property p_crystal_value; wr_run && wb_sel_i[1:0] == 2'h3 |=> crystal_value_o == $past(wb_dat_i[10:6]);
  endproperty
  a_crystal_value: assert property (p_crystal_value) else $error("crystal not written");
  property p_pulse; sys_clk_en_o |=> !sys_clk_en_o; endproperty
  a_pulse: assert property (p_pulse) else $error("runt clock pulse");
  c_auto: cover property (acg_q && sleep_i);
  c_write: cover property (wr_run);
  c_pulse: cover property (sys_clk_en_o);
endmodule // rcc_checker

bind rcc_top rcc_checker i_chk (.*);

// File: test/tb.sv
`timescale 1ns/100ps
module tb;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, sleep_i, deep_sleep_i;
  logic        main_osc_i, precision_internal_osc_i, lf_osc_i, pll_clk_i;
  logic [11:0] wb_adr_i;
  logic [3:0]  wb_sel_i, minimum_divisor_cap_i;
  logic [31:0] wb_dat_i, run_gating_set_i, sleep_gating_set_i, deep_sleep_gating_set_i, rd;
  wire  [31:0] wb_dat_o, periph_clk_en_o;
  wire         wb_ack_o, sys_clk_en_o, pll_power_down_o, pll_bypass_o;
  wire         main_osc_disable_o, precision_internal_osc_disable_o;
  wire  [4:0]  crystal_value_o;
  int          error_cnt, num_checks, k, i;
  logic [31:0] cfg [8] = '{32'h00002AC0, 32'h01C02AC0, 32'h008002C0, 32'h00C00AC0,
                           32'h00C00AC0, 32'h00002AD0, 32'h00002AE0, 32'h00002AF0};
  logic [31:0] sec [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h81000000, 32'h0, 32'h0, 32'h0};
  logic [31:0] exg [8] = '{32'h8, 32'h20, 32'h18, 32'h10, 32'h18, 32'hA, 32'h28, 32'hC};

  rcc_top i_dut (.*);

  always #12.5 clk_i = ~clk_i;

  // Slow source clocks made from the bench clock keep sync latency fixed, so gaps are exact.
  always @(posedge clk_i) begin
    k                        <= k + 1;
    main_osc_i               <= (k % 8) < 4;
    precision_internal_osc_i <= (k % 10) < 5;
    lf_osc_i                 <= (k % 12) < 6;
    pll_clk_i                <= (k % 6) < 3;
  end

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic we, input logic [11:0] adr, input logic [3:0] sel,
                     input logic [31:0] dat);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    n = 0;
    // Ack is sampled at the rising edge itself, where the registered value is settled.
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      error_cnt++;
      close_out;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // The first two gaps may straddle a source or divisor change, so only the third counts.
  task automatic gap(input logic [31:0] exp);
    int n;
    repeat (3) begin
      n = 0;
      do begin
        @(negedge clk_i);
        n++;
      end while (sys_clk_en_o !== 1'b1 && n < 300);
      if (n >= 300) begin
        error_cnt++;
        close_out;
      end
    end
    chk(n, exp);
  endtask

  task automatic gate(input logic s, input logic d, input logic [31:0] exp);
    @(posedge clk_i);
    sleep_i      <= s;
    deep_sleep_i <= d;
    repeat (3) @(posedge clk_i);
    chk(periph_clk_en_o, exp);
  endtask

  initial begin
    {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, sleep_i, deep_sleep_i, k} = '0;
    {main_osc_i, precision_internal_osc_i, lf_osc_i, pll_clk_i} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, error_cnt, num_checks} = '0;
    rst_i = 1'b1;
    minimum_divisor_cap_i = 4'h3;
    run_gating_set_i = 32'h1111AAAA;
    sleep_gating_set_i = 32'h22225555;
    deep_sleep_gating_set_i = 32'h4444CCCC;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({pll_power_down_o, pll_bypass_o, crystal_value_o}, 32'h6B);
    bus(1'b0, 12'h060, 4'hF, 32'h0);
    chk(rd, 32'h07803AD1);
    bus(1'b0, 12'h070, 4'hF, 32'h0);
    chk(rd, 32'h07800000);
    bus(1'b1, 12'h010, 4'hF, 32'hFFFFFFFF);
    bus(1'b0, 12'h010, 4'hF, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 12'h060, 4'hF, 32'hFFFFFFFF);
    bus(1'b0, 12'h060, 4'hF, 32'h0);
    chk(rd, 32'h0FC03FF3);
    chk(crystal_value_o, 32'h1F);
    bus(1'b1, 12'h060, 4'h1, 32'h0);
    bus(1'b0, 12'h060, 4'hF, 32'h0);
    chk(rd, 32'h0FC03F00);
    $display("test registers done");
    gate(1'b1, 1'b0, 32'h22225555);
    gate(1'b0, 1'b1, 32'h4444CCCC);
    gate(1'b1, 1'b1, 32'h4444CCCC);
    gate(1'b0, 1'b0, 32'h1111AAAA);
    bus(1'b1, 12'h060, 4'hF, 32'h07803AD1);
    gate(1'b1, 1'b0, 32'h1111AAAA);
    gate(1'b0, 1'b1, 32'h1111AAAA);
    gate(1'b0, 1'b0, 32'h1111AAAA);
    $display("test gating done");
    // Bypass is set before power down is raised again, as software must do.
    for (i = 0; i < 8; i++) begin
      bus(1'b1, 12'h070, 4'hF, sec[i]);
      bus(1'b1, 12'h060, 4'hF, cfg[i]);
      gap(exg[i]);
    end
    bus(1'b0, 12'h074, 4'hF, 32'h0);
    chk(rd, 32'h00000300);
    $display("test clock done");
    close_out;
  end
endmodule // tb
